// >>> core/asp_fifo.sv
// Purpose: valid/ready fifo for received configuration entries
// Assumes: single clock, depth a power of two
// Notes: full and empty are exact
`timescale 1ns/100ps
`default_nettype none
module asp_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : asp_fifo
`default_nettype wire

// >>> core/asp_pkg.sv
// Purpose: shared constants and types of the serial port and sequencer
// Assumes: 100 MHz system clock
// Notes: most numbers of the block live here; the sequencer still writes some as literals (8, 5'h10, 40)
package asp_pkg;
  // ***********************************************
  // configuration word layout
  // ***********************************************
  localparam int CFG_W = 8;
  localparam int WORD_VALID_BIT = 7;
  localparam int CH_MSB = 5;
  localparam int CH_LSB = 3;
  localparam int RG_MSB = 2;
  localparam int RG_LSB = 0;
  localparam logic [2:0] WORD_LAST_BIT = 3'h7;
  // ***********************************************
  // sequencer and packet
  // ***********************************************
  localparam int SEQ_DEPTH = 16;
  localparam logic [4:0] SEQ_DEPTH_V = 5'h10;
  localparam logic [4:0] DEFAULT_LEN = 5'h08;
  localparam logic [2:0] DEFAULT_RANGE = 3'h7;
  localparam int RESULT_W = 18;
  localparam int PKT_W = 24;
  localparam logic [4:0] PKT_LAST_IDX = 5'h17;
  localparam int FIFO_DEPTH = 16;
  // ***********************************************
  // timing
  // ***********************************************
  localparam int STARTUP_MS = 10;
  localparam int SYS_CLK_MHZ = 100;
  localparam int STARTUP_CYCLES = STARTUP_MS * 1000 * 1000 * SYS_CLK_MHZ / 1000;
  localparam int DRAIN_MAX_CYCLES = 40;
  // ***********************************************
  // types
  // ***********************************************
  typedef struct packed {
    logic [2:0] channel;
    logic [2:0] range_code;
  } asp_cfg_s;
  typedef struct packed {
    logic [RESULT_W-1:0] result;
    asp_cfg_s cfg;
  } asp_pkt_s;
  typedef enum logic [1:0] {CV_IDLE, CV_DRAIN, CV_BUSY} asp_conv_e;
endpackage : asp_pkg

// >>> core/asp_serial_seq.sv
// Purpose: serial port and channel/range sequencer of a multiplexed converter
// Assumes: shift clock is sampled by the 100 MHz clock, so it must stay well below it
// Notes: analog conversion sits outside; it gets a start pulse and returns a result
// Operation
// RQ1 - after reset convert channels 0..7 in order, all with range code 7
// RQ2 - up to 16 entries applied in order, wrapping after the last one
// RQ3 - accept 8-bit words in a window, ignore valid words after sixteenth
// RQ4 - word: bit 7 valid, bit 6 reserved, 5:3 channel, 2:0 range
// RQ5 - invalid words dropped, valid ones appended in order received
// RQ6 - host drives reserved bit 6 as zero
// RQ7 - convert start closes programming and drops any partial word
// RQ8 - any valid word replaces whole sequence; this conversion uses its first entry
// RQ9 - no valid word: keep sequence, advance pointer to next entry
// RQ10 - words only taken inside the window; new entry used with no delay
// RQ11 - window opens 10 ms after reset and at every busy fall
// RQ12 - host ends shifting 20 ns before next convert start
// RQ13 - packet of finished conversion loaded just before busy falls
// RQ14 - differential mode shifts out on both edges and echoes the clock
// RQ15 - differential mode samples input on both shift clock edges
// RQ16 - port active with chip select low, outputs released when high
// RQ17 - host holds shift clock low when idle in differential mode
// RQ18 - packet 24 bits msb first: result, channel, range
// RQ19 - extra clocks repeat the same 24-bit packet
// RQ20 - differential shift clock up to 250 MHz; here it must stay well below the 100 MHz clock that samples it
// RQ21 - host per-conversion patterns: word then zeros, or 24 zeros then word
// RQ22 - host clock minimum for 650 ns window: 19 MHz or 14 MHz
// RQ23 - one conversion per convert start edge with sequencer's entry
// RQ24 - single-ended mode samples and shifts on rising edges only
// RQ25 - interface select input chooses single-ended or differential
// RQ26 - packet channel and range are those actually used
// RQ27 - range code stored and reported unchanged
`timescale 1ns/100ps
`default_nettype none
module asp_serial_seq #(
  parameter int STARTUP_CYCLES = asp_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // serial pins
  input wire logic i_cs_n,
  input wire logic i_shift_clock_in,
  input wire logic i_serial_config_in,
  input wire logic i_diff_mode,
  output logic o_serial_result_out,
  output logic o_serial_result_out_oe,
  output logic o_shift_clock_echo,
  output logic o_shift_clock_echo_oe,
  // conversion control
  input wire logic i_convert_start,
  output logic o_busy,
  output logic o_conv_start,
  output asp_pkg::asp_cfg_s o_conv_cfg,
  // converter core
  input wire logic i_conv_done,
  input wire logic [asp_pkg::RESULT_W-1:0] i_conv_result
);
  // ***********************************************
  // functions
  // ***********************************************
  function automatic logic [3:0] next_idx(input logic [3:0] ptr, input logic [4:0] len);
    logic [4:0] nxt;
    nxt = {1'b0, ptr} + 5'h01;
    next_idx = (nxt >= len) ? 4'h0 : nxt[3:0];
  endfunction : next_idx

  function automatic logic pkt_bit(input asp_pkg::asp_pkt_s pkt, input logic [4:0] idx);
    logic [4:0] pos;
    pos = asp_pkg::PKT_LAST_IDX - idx;
    pkt_bit = pkt[pos];
  endfunction : pkt_bit

  // ***********************************************
  // pin synchronisers and edges
  // ***********************************************
  logic sck_s1, sck_s2, sck_s3;
  logic sdi_s1, sdi_s2;
  logic cs_s1, cs_s2;
  logic dm_s1, dm_s2;
  logic cnv_s1, cnv_s2, cnv_s3;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {sdi_s1, sdi_s2} <= 2'h0;
      {cs_s1, cs_s2} <= 2'h3;
      {dm_s1, dm_s2} <= 2'h0;
      {cnv_s1, cnv_s2, cnv_s3} <= 3'h0;
    end
    else
    begin
      {sck_s1, sck_s2, sck_s3} <= {i_shift_clock_in, sck_s1, sck_s2}; // [RQ20]
      {sdi_s1, sdi_s2} <= {i_serial_config_in, sdi_s1};
      {cs_s1, cs_s2} <= {i_cs_n, cs_s1};
      {dm_s1, dm_s2} <= {i_diff_mode, dm_s1};
      {cnv_s1, cnv_s2, cnv_s3} <= {i_convert_start, cnv_s1, cnv_s2};
    end
  end

  asp_pkg::asp_conv_e cv_q;
  logic active, sck_rise, sck_fall, shift_ev, start_edge, commit, done;
  assign active = ~cs_s2; // [RQ16]
  assign sck_rise = sck_s2 & ~sck_s3;
  assign sck_fall = ~sck_s2 & sck_s3;
  assign shift_ev = active & (sck_rise | (dm_s2 & sck_fall)); // [RQ15] [RQ24] [RQ25]
  assign start_edge = cnv_s2 & ~cnv_s3 & (cv_q == asp_pkg::CV_IDLE); // [RQ23]
  assign done = i_conv_done & (cv_q == asp_pkg::CV_BUSY);

  // ***********************************************
  // transaction window
  // ***********************************************
  logic [31:0] st_q;
  logic st_done_q;
  logic win_q;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_q <= '0;
      st_done_q <= 1'b0;
    end
    else if (!st_done_q)
    begin
      st_q <= st_q + 32'h0000_0001;
      st_done_q <= (st_q == 32'(STARTUP_CYCLES - 1)); // [RQ11]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      win_q <= 1'b0;
    end
    else if (start_edge)
    begin
      win_q <= 1'b0; // [RQ7]
    end
    else if (done || (!st_done_q && st_q == 32'(STARTUP_CYCLES - 1)))
    begin
      win_q <= 1'b1; // [RQ11]
    end
  end

  // ***********************************************
  // word deserialiser
  // ***********************************************
  logic [6:0] sh_q;
  logic [2:0] bit_q;
  logic [7:0] word;
  logic word_done, take;
  logic [4:0] acc_q;
  logic pend_q;
  asp_pkg::asp_cfg_s pend_cfg_q;
  logic fifo_in_ready, fifo_out_valid, drain_ready;
  asp_pkg::asp_cfg_s fifo_out_cfg;

  assign word = {sh_q, sdi_s2};
  assign word_done = shift_ev & (bit_q == asp_pkg::WORD_LAST_BIT) & ~start_edge;
  assign take = word_done & win_q & word[asp_pkg::WORD_VALID_BIT] // [RQ5] [RQ10]
    & (acc_q < asp_pkg::SEQ_DEPTH_V); // [RQ3]

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sh_q <= '0;
      bit_q <= '0;
    end
    else if (start_edge)
    begin
      bit_q <= '0; // [RQ7]
    end
    else if (shift_ev)
    begin
      sh_q <= word[6:0];
      bit_q <= bit_q + 3'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      acc_q <= '0;
    end
    else if (commit)
    begin
      acc_q <= '0;
    end
    else if (take)
    begin
      acc_q <= acc_q + 5'h01; // [RQ3]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pend_q <= 1'b0;
      pend_cfg_q <= '0;
    end
    else if (take)
    begin
      pend_q <= 1'b1;
      pend_cfg_q <= {word[asp_pkg::CH_MSB:asp_pkg::CH_LSB],
                     word[asp_pkg::RG_MSB:asp_pkg::RG_LSB]}; // [RQ4] [RQ27]
    end
    else if (fifo_in_ready)
    begin
      pend_q <= 1'b0;
    end
  end

  asp_fifo #(
    .WIDTH($bits(asp_pkg::asp_cfg_s)),
    .DEPTH(asp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(pend_q),
    .i_in_data(pend_cfg_q),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_cfg),
    .i_out_ready(drain_ready)
  );

  // ***********************************************
  // staging of the new sequence
  // ***********************************************
  asp_pkg::asp_cfg_s new_mem_q [asp_pkg::SEQ_DEPTH];
  logic [4:0] new_cnt_q;
  assign drain_ready = (new_cnt_q < asp_pkg::SEQ_DEPTH_V) & ~commit;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      new_cnt_q <= '0;
      for (int i = 0; i < asp_pkg::SEQ_DEPTH; i++)
      begin
        new_mem_q[i] <= '0;
      end
    end
    else if (commit)
    begin
      new_cnt_q <= '0;
    end
    else if (fifo_out_valid && drain_ready)
    begin
      new_mem_q[new_cnt_q[3:0]] <= fifo_out_cfg; // [RQ5]
      new_cnt_q <= new_cnt_q + 5'h01;
    end
  end

  // ***********************************************
  // conversion control and sequencer
  // ***********************************************
  asp_pkg::asp_cfg_s seq_mem_q [asp_pkg::SEQ_DEPTH];
  logic [4:0] len_q;
  logic [3:0] ptr_q;
  logic prog_q;
  assign commit = (cv_q == asp_pkg::CV_DRAIN) & ~pend_q & ~fifo_out_valid;

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cv_q <= asp_pkg::CV_IDLE;
    end
    else
    begin
      case (cv_q)
        asp_pkg::CV_IDLE: if (start_edge) cv_q <= asp_pkg::CV_DRAIN;
        asp_pkg::CV_DRAIN: if (commit) cv_q <= asp_pkg::CV_BUSY;
        asp_pkg::CV_BUSY: if (i_conv_done) cv_q <= asp_pkg::CV_IDLE;
        default: cv_q <= asp_pkg::CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      len_q <= asp_pkg::DEFAULT_LEN; // [RQ1]
      ptr_q <= '0;
      prog_q <= 1'b0;
      o_conv_cfg <= '0;
      for (int i = 0; i < asp_pkg::SEQ_DEPTH; i++)
      begin
        seq_mem_q[i] <= (i < 8) ? {3'(i), asp_pkg::DEFAULT_RANGE} : 6'h00; // [RQ1]
      end
    end
    else if (commit && new_cnt_q != 5'h00)
    begin
      seq_mem_q <= new_mem_q; // [RQ8]
      len_q <= new_cnt_q;
      o_conv_cfg <= new_mem_q[0]; // [RQ8] [RQ10]
      ptr_q <= next_idx(4'h0, new_cnt_q); // [RQ2]
      prog_q <= 1'b1;
    end
    else if (commit)
    begin
      o_conv_cfg <= seq_mem_q[ptr_q]; // [RQ9]
      ptr_q <= next_idx(ptr_q, len_q); // [RQ2] [RQ9]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_conv_start <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_conv_start <= commit; // [RQ23]
      if (commit)
      begin
        o_busy <= 1'b1;
      end
      else if (done)
      begin
        o_busy <= 1'b0;
      end
    end
  end

  // ***********************************************
  // result packet shifter
  // ***********************************************
  asp_pkg::asp_pkt_s pkt_q;
  logic [4:0] idx_q;
  logic [4:0] idx_nxt;
  assign idx_nxt = (idx_q == asp_pkg::PKT_LAST_IDX) ? 5'h00 : idx_q + 5'h01; // [RQ19]

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pkt_q <= '0;
      idx_q <= '0;
      o_serial_result_out <= 1'b0;
      o_shift_clock_echo <= 1'b0;
    end
    else if (done)
    begin
      pkt_q <= {i_conv_result, o_conv_cfg}; // [RQ13] [RQ18] [RQ26]
      idx_q <= '0;
      o_serial_result_out <= i_conv_result[asp_pkg::RESULT_W-1]; // [RQ18]
      o_shift_clock_echo <= 1'b0;
    end
    else if (shift_ev)
    begin
      idx_q <= idx_nxt;
      o_serial_result_out <= pkt_bit(pkt_q, idx_nxt); // [RQ14] [RQ24]
      o_shift_clock_echo <= dm_s2 ? sck_s2 : ~o_shift_clock_echo; // [RQ14]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_serial_result_out_oe <= 1'b0;
      o_shift_clock_echo_oe <= 1'b0;
    end
    else
    begin
      o_serial_result_out_oe <= active; // [RQ16]
      o_shift_clock_echo_oe <= active; // [RQ16]
    end
  end

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_start;
    start_edge;
  endsequence
  sequence s_commit;
    ##[1:40] commit;
  endsequence

  AST_START_COMMITS: assert property (s_start |-> s_commit) // [RQ23]
    else $error("convert start not committed in time");
  AST_DEFAULT_SEQ: assert property (!prog_q |-> len_q == asp_pkg::DEFAULT_LEN // [RQ1]
    && seq_mem_q[ptr_q].range_code == asp_pkg::DEFAULT_RANGE
    && seq_mem_q[ptr_q].channel == ptr_q[2:0])
    else $error("default sequence wrong");
  AST_PTR_WRAPS: assert property (ptr_q < len_q[3:0] || len_q == 5'h10) // [RQ2]
    else $error("pointer outside sequence");
  AST_ACCEPT_LIMIT: assert property (take |-> acc_q < 5'h10 && win_q) // [RQ3]
    else $error("word taken beyond limit or outside window");
  AST_INVALID_DROP: assert property (word_done && !word[7] && !commit |=> $stable(acc_q)) // [RQ5]
    else $error("invalid word was kept");
  AST_START_CLOSES: assert property (start_edge |=> !win_q && bit_q == 3'h0) // [RQ7]
    else $error("window not closed at convert start");
  AST_COMMIT_NEW: assert property (commit && new_cnt_q != 5'h00 |=> // [RQ8]
    len_q == $past(new_cnt_q) && o_conv_cfg == $past(new_mem_q[0]) && o_conv_start)
    else $error("new sequence not applied");
  AST_KEEP_ADVANCE: assert property (commit && new_cnt_q == 5'h00 |=> // [RQ9]
    ptr_q == next_idx($past(ptr_q), len_q) && $stable(len_q))
    else $error("pointer did not advance");
  AST_BUSY_FALL_WINDOW: assert property ($fell(o_busy) |-> win_q) // [RQ11]
    else $error("window not open at busy fall");
  AST_PACKET_LOAD: assert property (done |=> pkt_q.result == $past(i_conv_result) // [RQ13]
    && pkt_q.cfg == o_conv_cfg && !o_busy && idx_q == 5'h00)
    else $error("packet not loaded at end of conversion");
  AST_DIFF_ECHO: assert property (shift_ev && dm_s2 && !done |=> // [RQ14]
    o_shift_clock_echo == $past(sck_s2))
    else $error("clock echo not aligned");
  AST_SE_FALL_HOLD: assert property (active && !dm_s2 && sck_fall && !done |=> // [RQ24]
    $stable(o_serial_result_out) && $stable(idx_q))
    else $error("single-ended shifted on falling edge");
  AST_OE_CS: assert property (cs_s2 |=> !o_serial_result_out_oe // [RQ16]
    && !o_shift_clock_echo_oe)
    else $error("outputs driven with chip select high");
endmodule : asp_serial_seq
`default_nettype wire

// >>> verif/asp_host_model.sv
// Purpose: serial host model, shifts config bits in and packet bits out
// Assumes: shift clock period 125 ns, clock idles low
// Notes: input bit set mid half period, output sampled just before each edge, only before rising edges in single-ended mode
`timescale 1ns/100ps
`default_nettype none
module asp_host_model (
  // serial pins
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi,
  input wire logic i_sdo
);
  // ***********************************************
  // shift engine
  // ***********************************************
  logic [47:0] got;
  event got_ev;
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic shift(input logic [135:0] din, input int n, input bit diff, input bit chk);
    got = 48'h0000_0000_0000;
    o_cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++)
    begin
      #31.2;
      o_sdi = din[n-1-i];
      #31.3;
      got = {got[46:0], i_sdo};
      o_sck = diff ? ~o_sck : 1'b1;
      if (!diff)
      begin
        #62.5;
        o_sck = 1'b0;
      end
    end
    #62.5;
    o_sdi = 1'b0;
    o_sck = 1'b0;
    #62.5;
    o_cs_n = 1'b1;
    if (chk)
      -> got_ev;
  endtask : shift
endmodule : asp_host_model
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self-checking bench of the serial port and sequencer
// Assumes: startup count shortened to 200 cycles
// Notes: host model shifts the link, bench plays the converter core
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ***********************************************
  // clock, reset and pins
  // ***********************************************
  localparam int STARTUP = 200;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_diff_mode = 1'b1;
  logic i_convert_start = 1'b0;
  logic i_conv_done = 1'b0;
  logic [17:0] i_conv_result = 18'h0_0000;
  logic cs_n, sck, serial_config_in, serial_result_out, sdo_oe, echo, echo_oe, busy, conv_start;
  wire logic sdo_w;
  asp_pkg::asp_cfg_s conv_cfg;
  asp_pkg::asp_pkt_s last_pkt;
  asp_pkg::asp_cfg_s exp_cfg_q[$];
  logic [47:0] exp_pkt_q[$];
  logic [31:0] lfsr = 32'h9797_ccbc;
  logic [135:0] prog;
  int num_errors = 0;
  int checks_done = 0;
  int echo_edges = 0;
  int cur_n = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  assign sdo_w = sdo_oe ? serial_result_out : 1'bz;
  asp_serial_seq #(.STARTUP_CYCLES(STARTUP)) dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cs_n(cs_n),
    .i_shift_clock_in(sck), .i_serial_config_in(serial_config_in), .i_diff_mode(i_diff_mode),
    .o_serial_result_out(serial_result_out), .o_serial_result_out_oe(sdo_oe),
    .o_shift_clock_echo(echo), .o_shift_clock_echo_oe(echo_oe),
    .i_convert_start(i_convert_start), .o_busy(busy), .o_conv_start(conv_start),
    .o_conv_cfg(conv_cfg), .i_conv_done(i_conv_done), .i_conv_result(i_conv_result)
  );
  asp_host_model host (.o_cs_n(cs_n), .o_sck(sck), .o_sdi(serial_config_in), .i_sdo(sdo_w));
  // ***********************************************
  // compares and report
  // ***********************************************
  task automatic report(input bit ok, input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (!ok)
    begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : report
  task automatic cmp_cfg(input asp_pkg::asp_cfg_s got, input asp_pkg::asp_cfg_s exp);
    report(got === exp, 48'(got), 48'(exp));
  endtask : cmp_cfg
  task automatic cmp_pkt(input logic [47:0] got, input logic [47:0] exp);
    report(got === exp, got, exp);
  endtask : cmp_pkt
  task automatic cmp_cnt(input int got, input int exp);
    report(got == exp, 48'(got), 48'(exp));
  endtask : cmp_cnt
  task automatic cmp_oe(input logic [1:0] got);
    report(got === 2'h0, 48'(got), 48'h0000_0000_0000);
  endtask : cmp_oe
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // ***********************************************
  // monitors
  // ***********************************************
  always @(posedge i_sys_clk)
    if (conv_start === 1'b1)
      cmp_cfg(conv_cfg, exp_cfg_q.pop_front());
  always @(echo)
    if (cs_n === 1'b0)
      echo_edges++;
  always @(host.got_ev)
  begin
    cmp_pkt(host.got, exp_pkt_q.pop_front());
    cmp_cnt(echo_edges, cur_n);
    cmp_oe(~{sdo_oe, echo_oe});
  end
  // ***********************************************
  // converter core and steps
  // ***********************************************
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  function automatic logic [5:0] cfgw(input int k);
    return {k[2:0], k[5:3]};
  endfunction : cfgw
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 40)
    begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    if (busy !== lvl)
    begin
      report(1'b0, 48'(busy), 48'(lvl));
      end_of_test();
    end
  endtask : wait_busy
  task automatic conv(input logic [5:0] exp);
    exp_cfg_q.push_back(exp);
    @(posedge i_sys_clk);
    #1;
    i_convert_start = 1'b1;
    wait_busy(1'b1);
    i_convert_start = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    #1;
    lfsr = next_rand(lfsr);
    i_conv_result = lfsr[17:0];
    i_conv_done = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_conv_done = 1'b0;
    last_pkt = {lfsr[17:0], exp};
    wait_busy(1'b0);
  endtask : conv
  task automatic step(input logic [5:0] exp, input logic [135:0] din, input int n);
    conv(exp);
    cur_n = n;
    echo_edges = 0;
    if (n == 24 || n == 48)
      exp_pkt_q.push_back(n == 48 ? {last_pkt, last_pkt} : {24'h00_0000, last_pkt});
    host.shift(din, n, i_diff_mode, n == 24 || n == 48);
  endtask : step
  // ***********************************************
  // main sequence
  // ***********************************************
  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    host.shift(136'h9A, 8, 1'b1, 1'b0);
    repeat (STARTUP) @(posedge i_sys_clk);
    for (int i = 0; i < 9; i++)
      step({i[2:0], 3'h7}, i == 8 ? 136'h9A_3F_A1 : 136'h0, i == 8 ? 24 : 48);
    $display("test default sequence done");
    for (int k = 0; k < 17; k++)
      prog = {prog[127:0], 2'b10, cfgw(k)};
    step(6'h1A, 136'h0, 24);
    step(6'h21, 136'h0, 24);
    step(6'h1A, prog, 136);
    $display("test short program done");
    for (int k = 0; k < 17; k++)
      step(cfgw(k % 16), k == 16 ? 136'hF : 136'h0, k == 16 ? 4 : 24);
    $display("test full program done");
    @(posedge i_sys_clk);
    #1;
    i_diff_mode = 1'b0;
    step(cfgw(1), 136'hBF_0000, 24);
    step(6'h3F, 136'h0, 24);
    $display("test single edge mode done");
    repeat (5) @(posedge i_sys_clk);
    cmp_oe({sdo_oe, echo_oe});
    $display("test release done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
